/* core/vpic_pkg.sv */
// shared constants, field layout and carrier types of the vectored interrupt controller
package vpic_pkg;

  // source and level counts
  localparam int NUM_SRC = 32;
  localparam int NUM_LVL = 8;
  localparam int LVL_W = 3;
  localparam int SRC_W = 5;
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam int ADDR_W = 9;

  // register byte offsets
  localparam logic [8:0] OFF_MODE_BASE = 9'h000;
  localparam logic [8:0] OFF_VEC_BASE = 9'h080;
  localparam logic [8:0] OFF_CUR_VEC = 9'h100;
  localparam logic [8:0] OFF_FAST_VEC = 9'h104;
  localparam logic [8:0] OFF_STATUS = 9'h108;
  localparam logic [8:0] OFF_PEND = 9'h10c;
  localparam logic [8:0] OFF_EN_SET = 9'h110;
  localparam logic [8:0] OFF_EN_CLR = 9'h114;
  localparam logic [8:0] OFF_EN_MASK = 9'h118;
  localparam logic [8:0] OFF_PEND_SET = 9'h11c;
  localparam logic [8:0] OFF_PEND_CLR = 9'h120;
  localparam logic [8:0] OFF_EOS = 9'h124;
  localparam logic [8:0] OFF_FFE = 9'h128;
  localparam logic [8:0] OFF_DBG = 9'h12c;
  localparam logic [8:0] OFF_SPUR = 9'h130;

  // field positions
  localparam int MODE_PRIO_LSB = 0;
  localparam int MODE_KIND_LSB = 5;
  localparam int DBG_PROT_BIT = 0;
  localparam int DBG_GMSK_BIT = 1;
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_SP_LSB = 16;
  localparam int STAT_BUSY_BIT = 24;

  // reset values and the fixed fast source mask
  localparam logic [31:0] RST_VEC = 32'h0000_0000;
  localparam logic [31:0] RST_EN = 32'h0000_0000;
  localparam logic [31:0] RST_FFE = 32'h0000_0000;
  localparam logic [31:0] RST_SPUR = 32'h0000_0000;
  localparam logic [1:0] RST_DBG = 2'h0;
  localparam logic [31:0] FAST_SRC_BIT = 32'h0000_0001;

  // source sensitivity; internal sources use only bit 0 (edge) and act high
  typedef enum logic [1:0] {
    KIND_LOW_LVL = 2'b00,
    KIND_FALL_EDGE = 2'b01,
    KIND_HIGH_LVL = 2'b10,
    KIND_RISE_EDGE = 2'b11
  } vpic_kind_t;

  // per-source mode
  typedef struct packed {
    vpic_kind_t kind;
    logic [LVL_W-1:0] prio;
  } vpic_cfg_t;

  // one nesting stack entry
  typedef struct packed {
    logic [LVL_W-1:0] lvl;
    logic [SRC_W-1:0] src;
  } vpic_stk_t;

  localparam vpic_cfg_t RST_CFG = '{kind: KIND_LOW_LVL, prio: 3'h0};

endpackage : vpic_pkg

/* core/vpic_src_cond.sv */
// one source: synchroniser, sensitivity selection and pending flag
module vpic_src_cond
  import vpic_pkg::*;
#(
  parameter bit IS_EXT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic src_in,
  input wire vpic_kind_t kind,
  input wire logic clr,
  input wire logic sw_set,
  output logic pending
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic pend_ff;
  logic nxt_pend;
  wire act_high = IS_EXT ? kind[1] : 1'b1;
  wire is_edge = kind[0];
  wire lvl_act = act_high ? sync2_ff : ~sync2_ff;
  wire prev_act = act_high ? prev_ff : ~prev_ff;
  wire edge_hit = lvl_act & ~prev_act;

  // level follows the line; edge is sticky, set wins over clear
  assign nxt_pend = is_edge ? (edge_hit | sw_set | (pend_ff & ~clr)) : lvl_act;
  assign pending = pend_ff;

  // two-stage synchroniser, then history for edge detect
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      sync1_ff <= src_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      pend_ff <= nxt_pend;
    end
  end

endmodule : vpic_src_cond

/* core/vpic_ctrl.sv */
// vectored priority interrupt controller: sources, arbitration, nesting stack, registers
module vpic_ctrl
  import vpic_pkg::*;
#(
  parameter logic [31:0] EXT_MASK = 32'h0000_0001
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] src_in,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic fast_int_req_n,
  output logic normal_int_req_n
);

  // register state
  vpic_cfg_t cfg_ff [NUM_SRC];
  logic [31:0] vec_ff [NUM_SRC];
  logic [NUM_SRC-1:0] en_ff;
  logic [NUM_SRC-1:0] ffe_ff;
  logic [31:0] spur_ff;
  logic prot_ff;
  logic gmsk_ff;

  // nesting stack
  vpic_stk_t stk_ff [STK_DEPTH];
  logic [SP_W-1:0] sp_ff;

  // source status
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] src_clr;
  logic [NUM_SRC-1:0] src_set;

  // arbitration result
  logic best_vld;
  logic [SRC_W-1:0] best_src;
  logic [LVL_W-1:0] best_lvl;

  // address decode
  wire [SRC_W-1:0] idx = reg_addr[6:2];
  wire mode_sel = (reg_addr[8:7] == OFF_MODE_BASE[8:7]);
  wire vec_sel = (reg_addr[8:7] == OFF_VEC_BASE[8:7]);
  wire hit_cur = (reg_addr == OFF_CUR_VEC);
  wire hit_fast = (reg_addr == OFF_FAST_VEC);
  wire wr_mode = reg_wr & mode_sel;
  wire wr_vec = reg_wr & vec_sel;
  wire wr_en_set = reg_wr & (reg_addr == OFF_EN_SET);
  wire wr_en_clr = reg_wr & (reg_addr == OFF_EN_CLR);
  wire wr_pend_set = reg_wr & (reg_addr == OFF_PEND_SET);
  wire wr_pend_clr = reg_wr & (reg_addr == OFF_PEND_CLR);
  wire wr_eos = reg_wr & (reg_addr == OFF_EOS);
  wire wr_ffe = reg_wr & (reg_addr == OFF_FFE);
  wire wr_dbg = reg_wr & (reg_addr == OFF_DBG);
  wire wr_spur = reg_wr & (reg_addr == OFF_SPUR);

  // acknowledge: read normally; in protect mode only a write to the same address acts
  wire take_cur = prot_ff ? (reg_wr & hit_cur) : (reg_rd & hit_cur);
  wire take_fast = prot_ff ? (reg_wr & hit_fast) : (reg_rd & hit_fast);

  // current service context from the stack top
  wire stk_empty = (sp_ff == '0);
  wire stk_full = (sp_ff == SP_W'(STK_DEPTH));
  wire [SP_W-1:0] sp_top = sp_ff - 4'h1;
  wire vpic_stk_t top = stk_ff[sp_top[2:0]];
  wire [LVL_W-1:0] cur_lvl = stk_empty ? '0 : top.lvl;
  wire [SRC_W-1:0] cur_src = stk_empty ? '0 : top.src;

  // fast forcing; source 0 always goes to the fast request
  wire [NUM_SRC-1:0] ffe_eff = ffe_ff | FAST_SRC_BIT;
  wire [NUM_SRC-1:0] live = pend & en_ff;
  wire [NUM_SRC-1:0] cand = live & ~ffe_eff;

  // request terms
  wire fast_want = (|(live & ffe_eff)) & ~gmsk_ff;
  wire above = stk_empty | (best_lvl > cur_lvl);
  wire norm_want = best_vld & above & ~gmsk_ff;

  // pending clear sources: software, current-vector take, fast take
  wire [NUM_SRC-1:0] take_onehot = NUM_SRC'(1) << best_src;
  wire [NUM_SRC-1:0] clr_cur = (take_cur & best_vld) ? take_onehot : '0;
  wire [NUM_SRC-1:0] clr_fast = take_fast ? FAST_SRC_BIT : '0;
  assign src_clr = (wr_pend_clr ? reg_wdata : '0) | clr_cur | clr_fast;
  assign src_set = wr_pend_set ? reg_wdata : '0;

  // per-source conditioning
  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      vpic_src_cond #(
        .IS_EXT(EXT_MASK[g])
      ) u_cond (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src_in[g]),
        .kind(cfg_ff[g].kind),
        .clr(src_clr[g]),
        .sw_set(src_set[g]),
        .pending(pend[g])
      );
    end
  endgenerate

  // highest priority wins, lowest index on a tie; source 0 never competes
  always_comb begin
    best_vld = 1'b0;
    best_src = '0;
    best_lvl = '0;
    for (int i = 1; i < NUM_SRC; i++) begin
      if (cand[i] && (!best_vld || (cfg_ff[i].prio > best_lvl))) begin
        best_vld = 1'b1;
        best_src = SRC_W'(i);
        best_lvl = cfg_ff[i].prio;
      end
    end
  end

  // read data selection
  wire [31:0] mode_word = {25'h0, cfg_ff[idx].kind, 2'h0, cfg_ff[idx].prio};
  wire [31:0] cur_word = best_vld ? vec_ff[best_src] : spur_ff;
  wire [31:0] fast_word = vec_ff[0];
  wire [31:0] stat_word = (32'(cur_src) << STAT_SRC_LSB)
                        | (32'(cur_lvl) << STAT_LVL_LSB)
                        | (32'(sp_ff) << STAT_SP_LSB)
                        | (32'(!stk_empty) << STAT_BUSY_BIT);
  wire [31:0] dbg_word = (32'(prot_ff) << DBG_PROT_BIT) | (32'(gmsk_ff) << DBG_GMSK_BIT);
  wire [31:0] rd_mux =
      mode_sel ? mode_word :
      vec_sel ? vec_ff[idx] :
      hit_cur ? cur_word :
      hit_fast ? fast_word :
      (reg_addr == OFF_STATUS) ? stat_word :
      (reg_addr == OFF_PEND) ? pend :
      (reg_addr == OFF_EN_MASK) ? en_ff :
      (reg_addr == OFF_FFE) ? ffe_ff :
      (reg_addr == OFF_DBG) ? dbg_word :
      (reg_addr == OFF_SPUR) ? spur_ff :
      32'h0000_0000;

  // new stack entry for an acknowledge
  wire vpic_stk_t push_ent = '{lvl: best_lvl, src: best_src};
  wire do_push = take_cur & best_vld & ~stk_full;
  wire do_pop = wr_eos & ~stk_empty;

  // per-source mode and vector registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        cfg_ff[i] <= RST_CFG;
        vec_ff[i] <= RST_VEC;
      end
    end else begin
      if (wr_mode) begin
        cfg_ff[idx].prio <= reg_wdata[MODE_PRIO_LSB +: LVL_W];
        cfg_ff[idx].kind <= vpic_kind_t'(reg_wdata[MODE_KIND_LSB +: 2]);
      end
      if (wr_vec) begin
        vec_ff[idx] <= reg_wdata;
      end
    end
  end

  // enable, fast forcing, spurious vector and debug controls
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_ff <= RST_EN;
      ffe_ff <= RST_FFE;
      spur_ff <= RST_SPUR;
      prot_ff <= RST_DBG[DBG_PROT_BIT];
      gmsk_ff <= RST_DBG[DBG_GMSK_BIT];
    end else begin
      if (wr_en_set) begin
        en_ff <= en_ff | reg_wdata;
      end else if (wr_en_clr) begin
        en_ff <= en_ff & ~reg_wdata;
      end
      if (wr_ffe) begin
        ffe_ff <= reg_wdata;
      end
      if (wr_spur) begin
        spur_ff <= reg_wdata;
      end
      if (wr_dbg) begin
        prot_ff <= reg_wdata[DBG_PROT_BIT];
        gmsk_ff <= reg_wdata[DBG_GMSK_BIT];
      end
    end
  end

  // nesting stack: push on acknowledge, pop on end of service
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sp_ff <= '0;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk_ff[i] <= '0;
      end
    end else if (do_push) begin
      stk_ff[sp_ff[2:0]] <= push_ent;
      sp_ff <= sp_ff + 4'h1;
    end else if (do_pop) begin
      sp_ff <= sp_top;
    end
  end

  // registered read data, valid the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // request outputs, active low; acknowledge forces normal request off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_int_req_n <= 1'b1;
      normal_int_req_n <= 1'b1;
    end else begin
      fast_int_req_n <= ~fast_want;
      normal_int_req_n <= ~norm_want | take_cur;
    end
  end

  // level sources stay pending until the handler clears the line itself
  // (a level source still active after end of service will request again)

endmodule : vpic_ctrl

/* bench/vpic_ctrl_monitor.sv */
// port checker for the interrupt controller
module vpic_ctrl_monitor
  import vpic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] src_in,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic fast_int_req_n,
  input wire logic normal_int_req_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prot_ff;
  logic gmsk_ff;
  logic en_ff;
  wire dbg_wr = reg_wr && reg_addr == OFF_DBG;
  wire en_wr = reg_wr && reg_addr == OFF_EN_SET && reg_wdata != 32'h0;
  // shadows of protect, general mask and any enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prot_ff <= 1'b0;
      gmsk_ff <= 1'b0;
      en_ff <= 1'b0;
    end else begin
      prot_ff <= dbg_wr ? reg_wdata[DBG_PROT_BIT] : prot_ff;
      gmsk_ff <= dbg_wr ? reg_wdata[DBG_GMSK_BIT] : gmsk_ff;
      en_ff <= en_ff | en_wr;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // acknowledge and protected peek of the current vector
  sequence s_ack;
    reg_rd && reg_addr == OFF_CUR_VEC && !prot_ff;
  endsequence
  sequence s_peek;
    reg_rd && reg_addr == OFF_CUR_VEC && prot_ff && !gmsk_ff && !normal_int_req_n;
  endsequence
  a_rst_quiet: assert property ($fell(rst) |-> fast_int_req_n && normal_int_req_n)
    else $error("request active after reset");
  a_ack_drops: assert property (s_ack |=> normal_int_req_n)
    else $error("acknowledge left request low");
  a_peek_keeps: assert property (s_peek |=> !normal_int_req_n)
    else $error("protected read dropped request");
  a_mask_holds: assert property (gmsk_ff && $past(gmsk_ff) |-> fast_int_req_n && normal_int_req_n)
    else $error("request under general mask");
  a_idle_quiet: assert property (!en_ff |-> fast_int_req_n && normal_int_req_n)
    else $error("request with no source enabled");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (reg_rd && reg_addr > OFF_SPUR |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_wr_silent: assert property (reg_wr |=> reg_rdata == 32'h0)
    else $error("write produced read data");
endmodule : vpic_ctrl_monitor

bind vpic_ctrl vpic_ctrl_monitor u_vpic_ctrl_monitor (.sys_clk(sys_clk), .rst(rst),
  .src_in(src_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_int_req_n(fast_int_req_n),
  .normal_int_req_n(normal_int_req_n));

/* bench/vpic_cpu_model.sv */
// processor side: counts normal requests it takes
module vpic_cpu_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic normal_int_req_n,
  output logic [7:0] irq_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  logic req_n_ff;
  // one count per falling edge of the active-low request
  always_ff @(posedge sys_clk) begin
    req_n_ff <= normal_int_req_n;
    irq_taken <= rst ? 8'h0 : irq_taken + 8'(req_n_ff && !normal_int_req_n);
  end
endmodule : vpic_cpu_model

/* bench/vpic_ctrl_tb.sv */
// self-checking bench for the interrupt controller
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module vpic_ctrl_tb
  import vpic_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [8:0] a; logic [31:0] d; logic [31:0] e;} vpic_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] src_in = 32'h0000_0401;
  logic [8:0] reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic fast_int_req_n;
  logic normal_int_req_n;
  logic [7:0] irq_taken;
  int mismatches = 0;
  int n_compared = 0;
  vpic_row_t rows [5] = '{'{9'h080, 32'ha5a5_0001, 32'ha5a5_0001},
    '{9'h0fc, 32'h5a5a_f00f, 32'h5a5a_f00f}, '{OFF_SPUR, 32'h0000_0bad, 32'h0000_0bad},
    '{9'h134, 32'hffff_ffff, 32'h0}, '{OFF_PEND, 32'hffff_ffff, 32'h0}};
  always #2.5 sys_clk = ~sys_clk;
  vpic_ctrl #(.EXT_MASK(32'h0000_0401)) u_vpic_ctrl (.sys_clk(sys_clk), .rst(rst),
    .src_in(src_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_int_req_n(fast_int_req_n),
    .normal_int_req_n(normal_int_req_n));
  vpic_cpu_model u_vpic_cpu_model (.sys_clk(sys_clk), .rst(rst),
    .normal_int_req_n(normal_int_req_n), .irq_taken(irq_taken));
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // bus write and read, one-cycle strobes
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  // bounded wait for a request line to reach a level
  task automatic wait_lvl(input logic f, input logic v);
    int i;
    i = 0;
    #1;
    while ((f ? fast_int_req_n : normal_int_req_n) !== v && i < 40) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    `CHK(f ? fast_int_req_n : normal_int_req_n, v)
    if (i == 40) conclude();
  endtask : wait_lvl
  initial begin
    logic [31:0] q;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFF_EN_MASK, q);
    `CHK(q, RST_EN)
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a, q);
      `CHK(q, rows[k].e)
    end
    // src5 rise prio 3, src9 high prio 6, src7 high prio 4
    wr(9'h014, 32'h0000_0023);
    wr(9'h024, 32'h0000_0006);
    wr(9'h01c, 32'h0000_0004);
    wr(9'h094, 32'h0000_0505);
    wr(9'h0a4, 32'h0000_0909);
    wr(9'h09c, 32'h0000_0707);
    wr(OFF_EN_SET, 32'h0000_06a0);
    src_in[5] <= 1'b1;
    wait_lvl(1'b0, 1'b0);
    rd(OFF_CUR_VEC, q);
    `CHK(q, 32'h0000_0505)
    `CHK(normal_int_req_n, 1'b1)
    rd(OFF_STATUS, q);
    `CHK(q & 32'h000f_071f, 32'h0001_0305)
    rd(OFF_PEND, q);
    `CHK(q, 32'h0)
    src_in[9] <= 1'b1;
    wait_lvl(1'b0, 1'b0);
    rd(OFF_CUR_VEC, q);
    `CHK(q, 32'h0000_0909)
    src_in[7] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 `CHK(normal_int_req_n, 1'b1)
    src_in[9] <= 1'b0;
    wr(OFF_EOS, 32'h0);
    rd(OFF_STATUS, q);
    `CHK(q & 32'h000f_0700, 32'h0001_0300)
    wait_lvl(1'b0, 1'b0);
    // protected peek, then general mask
    wr(OFF_DBG, 32'h1);
    rd(OFF_CUR_VEC, q);
    `CHK(q, 32'h0000_0707)
    rd(OFF_STATUS, q);
    `CHK(q & 32'h000f_0000, 32'h0001_0000)
    wr(OFF_DBG, 32'h2);
    wait_lvl(1'b0, 1'b1);
    rd(OFF_PEND, q);
    `CHK(q, 32'h0000_0080)
    wr(OFF_DBG, 32'h0);
    wait_lvl(1'b0, 1'b0);
    // fast forcing of src7 and src10, then source 0
    wr(OFF_FFE, 32'h0000_0480);
    wait_lvl(1'b1, 1'b0);
    wait_lvl(1'b0, 1'b1);
    src_in[7] <= 1'b0;
    wait_lvl(1'b1, 1'b1);
    wr(OFF_EN_SET, 32'h0000_0001);
    src_in[0] <= 1'b0;
    wait_lvl(1'b1, 1'b0);
    src_in[0] <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      src_in[10] <= ~k[1];
      wr(9'h028, {25'h0, k[1:0], 5'h0});
      wr(OFF_PEND_CLR, 32'h0000_0400);
      wait_lvl(1'b1, 1'b1);
      src_in[10] <= k[1];
      wait_lvl(1'b1, 1'b0);
    end
    `CHK(irq_taken, 8'h04)
    conclude();
  end
endmodule : vpic_ctrl_tb
